// >>> logic/tws_pkg.sv
// shared constants of the timer / watchdog block with shared prescaler
// assumes one 200 MHz clock, all inputs but the synchronised count pin synchronous to it
//
// Summary of operation
// - watchdog counts on the always-running block clock, not instruction cycles
// - watchdog expiry while running pulses a full device reset
// - watchdog expiry while asleep wakes the device instead of resetting
// - watchdog held cleared and silent while enable config input is zero
// - unscaled watchdog period is nominally 18 ms
// - prescaler on watchdog stretches the period up to 1:128
// - clear-watchdog and sleep instructions clear watchdog and its prescaler
// - watchdog expiry clears the time-out status flag
// - source select zero: timer counts instruction cycles, or prescaler output
// - timer write blocks incrementing for the next two instruction cycles
// - source select one: timer counts external pin edges, edge bit picks polarity
// - one shared prescaler, assign bit picks owner, count not software visible
// - prescaler on timer gives ratios 1:2 to 1:256 in powers of two
// - timer register readable and writable, rollover FFh to 00h sets overflow flag
// - overflow interrupt request suppressed while overflow enable is zero
// - timer frozen during sleep so its overflow cannot wake the core
// - rate field 000..111 gives timer 1:2..1:256 and watchdog 1:1..1:128
// - edge select one counts high-to-low pin transitions
package tws_pkg;

	// ************************************************************
	// clock and timing
	// ************************************************************
	localparam int unsigned CLK_MHZ          = 200;
	localparam int unsigned WDT_PERIOD_US    = 18000;
	localparam int unsigned WDT_PERIOD_CYC   = WDT_PERIOD_US * CLK_MHZ;
	localparam int unsigned WRITE_INHIBIT_CY = 2;

	// ************************************************************
	// register offsets (index on the plain register port)
	// ************************************************************
	localparam logic [1:0] ADDR_TIMER  = 2'h0;
	localparam logic [1:0] ADDR_OPTION = 2'h1;
	localparam logic [1:0] ADDR_INTCTL = 2'h2;
	localparam logic [1:0] ADDR_STATUS = 2'h3;

	// ************************************************************
	// field positions and reset values
	// ************************************************************
	localparam int unsigned OPT_SRC_BIT    = 5;
	localparam int unsigned OPT_EDGE_BIT   = 4;
	localparam int unsigned OPT_ASSIGN_BIT = 3;
	localparam int unsigned OPT_RATE_LSB   = 0;
	localparam int unsigned INT_ENABLE_BIT = 5;
	localparam int unsigned INT_FLAG_BIT   = 2;
	localparam int unsigned STAT_TO_BIT    = 4;
	localparam logic [7:0]  OPTION_RESET   = 8'hFF;
	localparam logic [7:0]  TIMER_RESET    = 8'h00;
	localparam logic [7:0]  TIMER_MAX      = 8'hFF;
	localparam int unsigned PRESC_WIDTH    = 8;

	// ************************************************************
	// prescaler helpers
	// ************************************************************
	// divide exponent: timer owns at rate+1, watchdog at rate
	function automatic logic [3:0] presc_shift(input logic to_wdt, input logic [2:0] rate);
		presc_shift = to_wdt ? {1'b0, rate} : ({1'b0, rate} + 4'h1);
	endfunction

	// low bits that must all be one before the prescaler emits a tick
	function automatic logic [PRESC_WIDTH-1:0] presc_mask(input logic [3:0] shift);
		presc_mask = PRESC_WIDTH'((9'h001 << shift) - 9'h001);
	endfunction

endpackage

// >>> logic/tws_presc_if.sv
// carrier between the block and its shared prescaler
// assumes both ends on the same clock
`timescale 1ns/1ps
interface tws_presc_if;
	logic       tick_in;
	logic       clear;
	logic [3:0] shift;
	logic       tick_out;

	modport owner (output tick_in, output clear, output shift, input  tick_out);
	modport presc (input  tick_in, input  clear, input  shift, output tick_out);
endinterface

// >>> logic/tws_prescaler.sv
// shared power-of-two prescaler, count hidden from software
// assumes tick_in is a one-cycle pulse on the block clock
`timescale 1ns/1ps
module tws_prescaler
	import tws_pkg::*;
#(
	parameter int unsigned WIDTH = PRESC_WIDTH
) (
	input  wire logic  i_clk,
	input  wire logic  i_arst_n,
	input  wire logic  i_ce,
	tws_presc_if.presc p
);
	typedef struct packed {
		logic [WIDTH-1:0] cnt;
	} tws_presc_state_t;

	tws_presc_state_t st_reg;
	tws_presc_state_t st_next;
	logic [WIDTH-1:0] mask;

	// ************************************************************
	// divide and emit
	// ************************************************************
	// tick when every low bit of the selected ratio is set
	always_comb begin
		mask       = WIDTH'(presc_mask(p.shift));
		p.tick_out = p.tick_in && !p.clear && ((st_reg.cnt & mask) == mask);
		st_next    = st_reg;
		if (p.clear) begin
			st_next.cnt = '0;
		end else if (p.tick_in) begin
			st_next.cnt = st_reg.cnt + WIDTH'(1);
		end
	end

	// state register
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			st_reg <= '0;
		end else if (i_ce) begin
			st_reg <= st_next;
		end
	end
endmodule

// >>> logic/tws_timer_wdt.sv
// 8-bit timer/counter and watchdog sharing one prescaler
// assumes i_clk is the free-running on-chip oscillator and never stops;
// the core marks instruction cycles with i_instr_tick and stops them in sleep
//
// The plain strobed port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module tws_timer_wdt
	import tws_pkg::*;
#(
	parameter int unsigned WDT_CYCLES = WDT_PERIOD_CYC
) (
	input  wire logic       i_clk,
	input  wire logic       i_arst_n,
	input  wire logic       i_ce,
	input  wire logic [1:0] i_addr,
	input  wire logic [7:0] i_wdata,
	input  wire logic       i_wr,
	input  wire logic       i_rd,
	output logic [7:0]      o_rdata,
	input  wire logic       i_instr_tick,
	input  wire logic       i_clear_watchdog_instr,
	input  wire logic       i_sleep_instr,
	input  wire logic       i_watchdog_enable_config,
	input  wire logic       i_external_count_pin,
	output logic            o_timer_irq,
	output logic            o_wdt_reset,
	output logic            o_wake,
	output logic            o_sleeping
);
	import tws_pkg::*;

	localparam int unsigned WW = $clog2(WDT_CYCLES + 1);
	localparam logic [WW-1:0] WDT_LAST = WW'(WDT_CYCLES - 1);

	typedef struct packed {
		logic [7:0]    timer_count_reg;
		logic [7:0]    option_reg;
		logic          timer_overflow_enable;
		logic          timer_overflow_flag;
		logic          timeout_status_flag;
		logic          sleeping;
		logic [1:0]    inhibit;
		logic          pin_s1;
		logic          pin_s2;
		logic          pin_s3;
		logic [WW-1:0] watchdog_counter;
		logic [7:0]    rdata;
		logic          wdt_reset;
		logic          wake;
		logic          irq;
	} tws_state_t;

	tws_state_t  st_reg;
	tws_state_t  st_next;
	tws_presc_if presc_bus ();

	logic       timer_source_select;
	logic       count_edge_select_bit;
	logic       prescaler_assign;
	logic [2:0] prescaler_rate_field;
	logic       run_cycle;
	logic       pin_edge;
	logic       timer_src_tick;
	logic       timer_inc;
	logic       wdt_base_tick;
	logic       wdt_expire;
	logic       wdt_clear;
	logic       timer_write;

	// ************************************************************
	// option fields
	// ************************************************************
	assign timer_source_select   = st_reg.option_reg[OPT_SRC_BIT];
	assign count_edge_select_bit = st_reg.option_reg[OPT_EDGE_BIT];
	assign prescaler_assign      = st_reg.option_reg[OPT_ASSIGN_BIT];
	assign prescaler_rate_field  = st_reg.option_reg[OPT_RATE_LSB +: 3];

	// ************************************************************
	// timer source
	// ************************************************************
	// instruction cycles only exist while awake
	assign run_cycle   = i_instr_tick && !st_reg.sleeping;
	assign timer_write = i_wr && (i_addr == ADDR_TIMER);
	// edge seen between the second and third synchroniser stages
	always_comb begin
		if (count_edge_select_bit) begin
			pin_edge = st_reg.pin_s3 && !st_reg.pin_s2;
		end else begin
			pin_edge = !st_reg.pin_s3 && st_reg.pin_s2;
		end
	end
	// sleep freezes both sources
	always_comb begin
		if (timer_source_select) begin
			timer_src_tick = pin_edge && !st_reg.sleeping;
		end else begin
			timer_src_tick = run_cycle;
		end
	end

	// ************************************************************
	// watchdog base period
	// ************************************************************
	// counts the free-running clock, so sleep does not stop it
	assign wdt_base_tick = i_watchdog_enable_config && (st_reg.watchdog_counter == WDT_LAST);
	assign wdt_clear     = i_clear_watchdog_instr || i_sleep_instr;

	// ************************************************************
	// shared prescaler hookup
	// ************************************************************
	// one prescaler, owner picked by the assign bit
	always_comb begin
		presc_bus.shift = presc_shift(prescaler_assign, prescaler_rate_field);
		if (prescaler_assign) begin
			presc_bus.tick_in = wdt_base_tick && !wdt_clear;
			presc_bus.clear   = wdt_clear || !i_watchdog_enable_config;
		end else begin
			presc_bus.tick_in = timer_src_tick;
			presc_bus.clear   = timer_write;
		end
	end

	tws_prescaler #(
		.WIDTH (PRESC_WIDTH)
	) u_presc (
		.i_clk    (i_clk),
		.i_arst_n (i_arst_n),
		.i_ce     (i_ce),
		.p        (presc_bus)
	);

	// timer step and watchdog expiry after the optional prescaler
	always_comb begin
		if (prescaler_assign) begin
			timer_inc  = timer_src_tick;
			wdt_expire = presc_bus.tick_out && i_watchdog_enable_config;
		end else begin
			timer_inc  = presc_bus.tick_out;
			wdt_expire = wdt_base_tick && !wdt_clear;
		end
	end

	// ************************************************************
	// next state
	// ************************************************************
	always_comb begin
		st_next           = st_reg;
		st_next.wdt_reset = 1'b0;
		st_next.wake      = 1'b0;

		// two-stage synchroniser plus edge history
		st_next.pin_s1 = i_external_count_pin;
		st_next.pin_s2 = st_reg.pin_s1;
		st_next.pin_s3 = st_reg.pin_s2;

		// watchdog counter: disabled, cleared, wrapped or counting
		if (!i_watchdog_enable_config || wdt_clear || wdt_base_tick) begin
			st_next.watchdog_counter = '0;
		end else begin
			st_next.watchdog_counter = st_reg.watchdog_counter + WW'(1);
		end

		// sleep entry and the clear-instruction status update
		if (i_sleep_instr) begin
			st_next.sleeping = 1'b1;
		end
		if (wdt_clear) begin
			st_next.timeout_status_flag = 1'b1;
		end

		// expiry: reset when running, wake when asleep; clear of flag wins
		if (wdt_expire) begin
			st_next.timeout_status_flag = 1'b0;
			if (st_reg.sleeping) begin
				st_next.wake     = 1'b1;
				st_next.sleeping = 1'b0;
			end else begin
				st_next.wdt_reset = 1'b1;
			end
		end

		// write inhibit window counts instruction cycles
		if (run_cycle && (st_reg.inhibit != 2'h0)) begin
			st_next.inhibit = st_reg.inhibit - 2'h1;
		end

		// timer increment and rollover
		if (timer_inc && (st_reg.inhibit == 2'h0)) begin
			st_next.timer_count_reg = st_reg.timer_count_reg + 8'h01;
		end

		// register writes
		if (i_wr) begin
			unique case (i_addr)
				ADDR_TIMER: begin
					st_next.timer_count_reg = i_wdata;
					st_next.inhibit         = 2'(WRITE_INHIBIT_CY);
				end
				ADDR_OPTION: begin
					st_next.option_reg = i_wdata;
				end
				ADDR_INTCTL: begin
					st_next.timer_overflow_enable = i_wdata[INT_ENABLE_BIT];
					st_next.timer_overflow_flag   = i_wdata[INT_FLAG_BIT];
				end
				ADDR_STATUS: begin
					st_next.timeout_status_flag = st_next.timeout_status_flag;
				end
			endcase
		end

		// overflow flag set beats a clearing write in the same cycle
		if (timer_inc && (st_reg.inhibit == 2'h0) && !timer_write && (st_reg.timer_count_reg == TIMER_MAX)) begin
			st_next.timer_overflow_flag = 1'b1;
		end

		// masked interrupt request
		st_next.irq = st_next.timer_overflow_flag && st_next.timer_overflow_enable;

		// read data one cycle after the strobe
		if (i_rd) begin
			unique case (i_addr)
				ADDR_TIMER: begin
					st_next.rdata = st_reg.timer_count_reg;
				end
				ADDR_OPTION: begin
					st_next.rdata = st_reg.option_reg;
				end
				ADDR_INTCTL: begin
					st_next.rdata                 = 8'h00;
					st_next.rdata[INT_ENABLE_BIT] = st_reg.timer_overflow_enable;
					st_next.rdata[INT_FLAG_BIT]   = st_reg.timer_overflow_flag;
				end
				ADDR_STATUS: begin
					st_next.rdata              = 8'h00;
					st_next.rdata[STAT_TO_BIT] = st_reg.timeout_status_flag;
				end
			endcase
		end
	end

	// ************************************************************
	// state register
	// ************************************************************
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			st_reg                     <= '0;
			st_reg.timer_count_reg     <= TIMER_RESET;
			st_reg.option_reg          <= OPTION_RESET;
			st_reg.timeout_status_flag <= 1'b1;
		end else if (i_ce) begin
			st_reg <= st_next;
		end
	end

	// outputs straight from the state register
	assign o_rdata     = st_reg.rdata;
	assign o_timer_irq = st_reg.irq;
	assign o_wdt_reset = st_reg.wdt_reset;
	assign o_wake      = st_reg.wake;
	assign o_sleeping  = st_reg.sleeping;
endmodule

// >>> bench/tws_timer_wdt_props.sv
// assertions on the top ports of the timer / watchdog block
// assumes it is bound to tws_timer_wdt and sees only its ports
`timescale 1ns/1ps
module tws_timer_wdt_props
	import tws_pkg::*;
#(
	parameter int unsigned WDT_CYCLES = 20
) (
	input wire logic       i_clk,
	input wire logic       i_arst_n,
	input wire logic       i_ce,
	input wire logic [1:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic       i_wr,
	input wire logic       i_rd,
	input wire logic [7:0] o_rdata,
	input wire logic       i_instr_tick,
	input wire logic       i_clear_watchdog_instr,
	input wire logic       i_sleep_instr,
	input wire logic       i_watchdog_enable_config,
	input wire logic       i_external_count_pin,
	input wire logic       o_timer_irq,
	input wire logic       o_wdt_reset,
	input wire logic       o_wake,
	input wire logic       o_sleeping
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_arst_n);

	// ************************************************************
	// shadow of option and overflow enable
	// ************************************************************
	logic [7:0] opt_reg;
	logic       en_reg;
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			opt_reg <= OPTION_RESET;
			en_reg  <= 1'b0;
		end else if (i_ce && i_wr && i_addr == ADDR_OPTION) begin
			opt_reg <= i_wdata;
		end else if (i_ce && i_wr && i_addr == ADDR_INTCTL) begin
			en_reg <= i_wdata[INT_ENABLE_BIT];
		end
	end

	// ************************************************************
	// properties
	// ************************************************************
	a_wdt_off_quiet: assert property (!i_watchdog_enable_config && $past(!i_watchdog_enable_config)
		|-> !o_wdt_reset && !o_wake) else $error("watchdog fired while disabled");
	a_reset_single: assert property (o_wdt_reset |=> !o_wdt_reset)
		else $error("watchdog reset longer than one cycle");
	a_wake_asleep: assert property (o_wake |-> $past(o_sleeping) && !o_wdt_reset)
		else $error("wake without sleep or with reset");
	a_wake_exit: assert property (o_wake |-> ##[0:1] !o_sleeping)
		else $error("still asleep after wake");
	a_sleep_entry: assert property (i_ce && i_sleep_instr |=> o_sleeping)
		else $error("sleep not entered");
	a_clear_holds: assert property (i_ce && i_clear_watchdog_instr && !o_sleeping
		|=> (!o_wdt_reset)[*8]) else $error("watchdog expired right after clear");
	a_irq_masked: assert property (!en_reg && !$past(en_reg) |-> !o_timer_irq)
		else $error("interrupt while masked");
	a_irq_sticky: assert property ($fell(o_timer_irq) |-> $past(i_wr) || $past(i_wr, 2))
		else $error("interrupt dropped without a write");
	a_option_back: assert property (i_ce && i_rd && i_addr == ADDR_OPTION |=> o_rdata == opt_reg)
		else $error("option readback wrong");
	a_rdata_hold: assert property (!$past(i_rd) |-> $stable(o_rdata))
		else $error("read data moved without a read");
endmodule

// >>> bench/tws_core_model.sv
// core and count-pin source: issues a counted burst of instruction ticks or pin toggles
// assumes one step every four clocks; pin starts low
`timescale 1ns/1ps
module tws_core_model (
	input  wire logic        i_clk,
	input  wire logic        i_start,
	input  wire logic        i_pin_mode,
	input  wire logic [15:0] i_count,
	output logic             o_instr_tick,
	output logic             o_pin,
	output logic             o_busy
);
	logic [15:0] left_reg = 16'h0000;
	logic [1:0]  div_reg  = 2'h0;
	initial o_instr_tick = 1'b0;
	initial o_pin = 1'b0;
	// one tick pulse or one pin toggle per step
	always @(posedge i_clk) begin
		o_instr_tick <= 1'b0;
		if (i_start) begin
			left_reg <= i_count;
			div_reg  <= 2'h0;
		end else if (left_reg != 16'h0000) begin
			div_reg <= div_reg + 2'h1;
			if (div_reg == 2'h3) begin
				left_reg <= left_reg - 16'h0001;
				if (i_pin_mode) o_pin <= ~o_pin;
				else o_instr_tick <= 1'b1;
			end
		end
	end
	assign o_busy = (left_reg != 16'h0000);
endmodule

// >>> bench/tws_timer_wdt_tb.sv
// self-checking bench of the timer / watchdog block
// assumes the core model drives ticks and the count pin
`timescale 1ns/1ps
module tws_timer_wdt_tb;
	import tws_pkg::*;
	localparam int unsigned WDT_CYCLES = 20;
	typedef struct packed {logic [7:0] opt; logic pin; logic [15:0] n; logic [7:0] delta;} tws_row_t;
	logic        i_clk, i_arst_n, i_ce, i_wr, i_rd, i_clr, i_slp, i_cfg, start, pin_mode;
	logic        tick, pin, busy, o_timer_irq, o_wdt_reset, o_wake, o_sleeping;
	logic [1:0]  i_addr;
	logic [7:0]  i_wdata, o_rdata, d, t;
	logic [15:0] cnt;
	int          failures, compares, n;
	tws_row_t    rows [11];

	tws_timer_wdt #(.WDT_CYCLES(WDT_CYCLES)) tws_timer_wdt_i (.i_clk(i_clk), .i_arst_n(i_arst_n),
		.i_ce(i_ce), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
		.i_instr_tick(tick), .i_clear_watchdog_instr(i_clr), .i_sleep_instr(i_slp),
		.i_watchdog_enable_config(i_cfg), .i_external_count_pin(pin), .o_timer_irq(o_timer_irq),
		.o_wdt_reset(o_wdt_reset), .o_wake(o_wake), .o_sleeping(o_sleeping));
	tws_core_model tws_core_model_i (.i_clk(i_clk), .i_start(start), .i_pin_mode(pin_mode),
		.i_count(cnt), .o_instr_tick(tick), .o_pin(pin), .o_busy(busy));

	initial begin
		i_clk = 1'b0;
		forever #2.5 i_clk = ~i_clk;
	end

	// ************************************************************
	// tasks
	// ************************************************************
	task automatic finish_test();
		$display("counts: %0d compares, %0d failures", compares, failures);
		if (failures == 0 && compares > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			failures++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tmo();
		failures++;
		$display("BAD %0t wait ran out", $time);
		finish_test();
	endtask
	task automatic wr(input logic [1:0] a, input logic [7:0] v);
		@(posedge i_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= v;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask
	task automatic rd(input logic [1:0] a, output logic [7:0] v);
		@(posedge i_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1;
		v = o_rdata;
	endtask
	// one-cycle clear-watchdog or sleep pulse
	task automatic pulse(input logic s);
		@(posedge i_clk);
		if (s) i_slp <= 1'b1;
		else i_clr <= 1'b1;
		@(posedge i_clk);
		i_slp <= 1'b0;
		i_clr <= 1'b0;
		#1;
	endtask
	task automatic run(input logic pm, input logic [15:0] k);
		@(posedge i_clk);
		start <= 1'b1;
		pin_mode <= pm;
		cnt <= k;
		@(posedge i_clk);
		start <= 1'b0;
		#1;
		for (n = 0; n < 4000 && busy; n++) begin
			@(posedge i_clk);
			#1;
		end
		if (busy) tmo();
		repeat (6) @(posedge i_clk);
	endtask
	task automatic wait_ev(input logic wk, input int lim, output int k);
		for (k = 1; k <= lim; k++) begin
			@(posedge i_clk);
			#1;
			if ((wk ? o_wake : o_wdt_reset) === 1'b1) return;
		end
		tmo();
	endtask
	task automatic idle(input int c, output int p);
		p = 0;
		repeat (c) begin
			@(posedge i_clk);
			#1;
			if (o_wdt_reset === 1'b1 || o_wake === 1'b1) p++;
		end
	endtask

	// ************************************************************
	// main sequence
	// ************************************************************
	initial begin
		{i_wr, i_rd, i_clr, i_slp, i_cfg, start, pin_mode, i_arst_n} = 8'h00;
		i_ce = 1'b1;
		i_addr = 2'h0;
		i_wdata = 8'h00;
		cnt = 16'h0000;
		failures = 0;
		compares = 0;
		repeat (16) @(posedge i_clk);
		i_arst_n <= 1'b1;
		rd(ADDR_TIMER, d);
		chk(d, TIMER_RESET);
		rd(ADDR_OPTION, d);
		chk(d, OPTION_RESET);
		rd(ADDR_INTCTL, d);
		chk(d, 8'h00);
		rd(ADDR_STATUS, d);
		chk(d, 8'h10);
		$display("test reset done");
		// timer prescaler rates, unscaled count, both pin edges
		for (int r = 0; r < 8; r++) rows[r] = '{8'(r), 1'b0, 16'(3 << (r + 1)), 8'h03};
		rows[8] = '{8'h08, 1'b0, 16'h0005, 8'h05};
		rows[9] = '{8'h28, 1'b1, 16'h0003, 8'h02};
		rows[10] = '{8'h38, 1'b1, 16'h0003, 8'h02};
		foreach (rows[r]) begin
			wr(ADDR_OPTION, rows[r].opt);
			rd(ADDR_TIMER, t);
			run(rows[r].pin, rows[r].n);
			rd(ADDR_TIMER, d);
			chk(d - t, rows[r].delta);
		end
		$display("test table done");
		// overflow flag, mask and write inhibit
		// instruction-cycle source, prescaler kept away from the timer
		wr(ADDR_OPTION, 8'h08);
		wr(ADDR_INTCTL, 8'h20);
		wr(ADDR_TIMER, 8'hFE);
		run(1'b0, 16'h0004);
		rd(ADDR_TIMER, d);
		chk(d, 8'h00);
		rd(ADDR_INTCTL, d);
		chk(d, 8'h24);
		idle(8, n);
		chk({7'h00, o_timer_irq}, 8'h01);
		wr(ADDR_INTCTL, 8'h20);
		idle(3, n);
		chk({7'h00, o_timer_irq}, 8'h00);
		wr(ADDR_INTCTL, 8'h00);
		wr(ADDR_TIMER, 8'hFE);
		run(1'b0, 16'h0004);
		rd(ADDR_INTCTL, d);
		chk(d, 8'h04);
		chk({7'h00, o_timer_irq}, 8'h00);
		$display("test overflow done");
		// watchdog period, status flag, clears
		@(posedge i_clk);
		i_cfg <= 1'b1;
		wr(ADDR_OPTION, 8'h00);
		pulse(1'b0);
		wait_ev(1'b0, 40, n);
		chk(8'(n >= 18 && n <= 23), 8'h01);
		rd(ADDR_STATUS, d);
		chk(d, 8'h00);
		pulse(1'b0);
		rd(ADDR_STATUS, d);
		chk(d, 8'h10);
		for (int k = 0; k < 12; k++) begin
			pulse(1'b0);
			idle(8, n);
			chk(8'(n), 8'h00);
		end
		wr(ADDR_OPTION, 8'h0A);
		pulse(1'b0);
		wait_ev(1'b0, 120, n);
		chk(8'(n >= 78 && n <= 83), 8'h01);
		$display("test watchdog done");
		// sleep: timer frozen, watchdog wakes
		rd(ADDR_TIMER, t);
		pulse(1'b1);
		chk({7'h00, o_sleeping}, 8'h01);
		run(1'b0, 16'h000A);
		rd(ADDR_TIMER, d);
		chk(d, t);
		wait_ev(1'b1, 100, n);
		idle(1, n);
		chk({7'h00, o_sleeping}, 8'h00);
		@(posedge i_clk);
		i_cfg <= 1'b0;
		wr(ADDR_OPTION, 8'h00);
		idle(60, n);
		chk(8'(n), 8'h00);
		$display("test sleep done");
		// second reset in mid-run
		@(posedge i_clk);
		i_arst_n <= 1'b0;
		repeat (2) @(posedge i_clk);
		i_arst_n <= 1'b1;
		rd(ADDR_OPTION, d);
		chk(d, OPTION_RESET);
		$display("test second reset done");
		finish_test();
	end
endmodule

bind tws_timer_wdt tws_timer_wdt_props #(.WDT_CYCLES(WDT_CYCLES)) props_i (.i_clk(i_clk),
	.i_arst_n(i_arst_n), .i_ce(i_ce), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
	.o_rdata(o_rdata), .i_instr_tick(i_instr_tick), .i_clear_watchdog_instr(i_clear_watchdog_instr),
	.i_sleep_instr(i_sleep_instr), .i_watchdog_enable_config(i_watchdog_enable_config),
	.i_external_count_pin(i_external_count_pin), .o_timer_irq(o_timer_irq),
	.o_wdt_reset(o_wdt_reset), .o_wake(o_wake), .o_sleeping(o_sleeping));
